/* ecr_gen_model.sv */
`timescale 1ns/1ps
// generator peripherals on clk_sys: single-cycle pulses and slow levels
module ecr_gen_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic split,
  input wire logic rogue,
  output logic [2:0] conv = 3'h0,
  output logic tmr_ovf = 1'b0,
  output logic tmr_high_byte_underflow = 1'b0,
  output logic [2:0] tmr_cmp = 3'h0,
  output logic [1:0] cap = 2'h0,
  output logic baud = 1'b0,
  output logic sck = 1'b0,
  input wire logic user_ev,
  output logic [7:0] user_cnt = 8'h00
);
  logic [3:0] baud_cnt = 4'h0;
  logic user_ev_d = 1'b0;
  logic [3:0] sck_cnt = 4'h0;

  // pulses never back to back, so each lasts exactly one cycle
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      {conv, tmr_ovf, tmr_high_byte_underflow, tmr_cmp, cap} <= 10'h000;
    end else begin
      conv <= 3'($urandom) & ~conv;
      tmr_ovf <= 1'($urandom) & ~tmr_ovf;
      tmr_cmp <= 3'($urandom) & ~tmr_cmp;
      cap <= 2'($urandom) & ~cap;
      // rogue lets the bench see the split gating in the router
      tmr_high_byte_underflow <= (split | rogue) & 1'($urandom) & ~tmr_high_byte_underflow;
    end
  end

  // timer-style user on a sync subchannel: a rising edge restarts it,
  // otherwise it counts up while low and down while high
  always @(posedge clk_sys) begin
    user_ev_d <= user_ev;
    if (user_ev && !user_ev_d) begin
      user_cnt <= 8'h00;
    end else if (user_ev) begin
      user_cnt <= user_cnt - 8'h01;
    end else begin
      user_cnt <= user_cnt + 8'h01;
    end
  end

  // clock levels hold two to five cycles
  always @(posedge clk_sys) begin
    if (baud_cnt == 4'h0) begin
      baud <= ~baud;
      baud_cnt <= 4'(1 + $urandom_range(3));
    end else begin
      baud_cnt <= baud_cnt - 4'h1;
    end
    if (sck_cnt == 4'h0) begin
      sck <= ~sck;
      sck_cnt <= 4'(1 + $urandom_range(3));
    end else begin
      sck_cnt <= sck_cnt - 4'h1;
    end
  end
endmodule

/* ecr_pkg.sv */
package ecr_pkg;
  // channel and pin counts
  localparam int NUM_CH = 6;
  localparam int NUM_LUT = 4;
  localparam int NUM_PIN = 8;
  localparam int NUM_EVO = 2;
  localparam int NUM_TCMP = 3;
  localparam int SYNC_STAGES = 2;
  localparam int PIT_CNT_W = 13;
  // tap bit for the first selector code on even and odd channels
  localparam int PIT_TOP_EVEN = 12;
  localparam int PIT_TOP_ODD = 8;
  localparam int CLK_PERIOD_NS = 25;

  // register offsets and the selector reset value
  localparam logic [7:0] OFS_CH0 = 8'h10;
  localparam logic [7:0] OFS_EVO0 = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h28;
  localparam logic [7:0] RST_SEL = 8'h00;

  // generator selector codes and group masks
  localparam logic [7:0] GEN_OFF = 8'h00;
  localparam logic [7:0] GEN_RTC_OVF = 8'h06;
  localparam logic [7:0] GEN_RTC_CMP = 8'h07;
  localparam logic [7:0] GEN_PIT_BASE = 8'h08;
  localparam logic [7:0] GEN_LUT_BASE = 8'h10;
  localparam logic [7:0] GEN_AC = 8'h20;
  localparam logic [7:0] GEN_CONV_RES = 8'h24;
  localparam logic [7:0] GEN_CONV_SAMPLE_READY = 8'h25;
  localparam logic [7:0] GEN_CONV_WINDOW_COMPARE_MATCH = 8'h26;
  localparam logic [7:0] GEN_PIN_BASE = 8'h40;
  localparam logic [7:0] GEN_USART = 8'h60;
  localparam logic [7:0] GEN_SPI = 8'h61;
  localparam logic [7:0] GEN_TMR_OVF = 8'h80;
  localparam logic [7:0] GEN_TMR_HIGH_BYTE_UNDERFLOW = 8'h81;
  localparam logic [7:0] GEN_TMR_CMP_BASE = 8'h84;
  localparam logic [7:0] GEN_CAP_CAPTURE_EVENT_INPUT = 8'ha0;
  localparam logic [7:0] GEN_CAP_OVF = 8'ha1;
  localparam logic [7:0] MASK_GRP4 = 8'hfc;
  localparam logic [7:0] MASK_GRP8 = 8'hf8;
endpackage

/* ecr_router.sv */
`timescale 1ns/1ps
module ecr_router
  import ecr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rtc_overflow,
  input wire logic rtc_compare,
  input wire logic rtc_prescaled_clk,
  input wire logic [ecr_pkg::NUM_LUT-1:0] lookup_output,
  input wire logic analog_comparator,
  input wire logic [ecr_pkg::NUM_PIN-1:0] port_pin,
  input wire logic converter_result_ready,
  input wire logic converter_sample_ready,
  input wire logic converter_window_compare_match,
  input wire logic serial_baud_clock,
  input wire logic spi_host_clock,
  input wire logic wide_timer_split,
  input wire logic wide_timer_overflow_or_low_underflow,
  input wire logic wide_timer_high_byte_underflow,
  input wire logic [ecr_pkg::NUM_TCMP-1:0] wide_timer_compare_match,
  input wire logic capture_timer_capture_event_input,
  input wire logic capture_timer_ovf,
  output logic [ecr_pkg::NUM_CH-1:0] chan_async,
  output logic [ecr_pkg::NUM_CH-1:0] chan_sync,
  output logic [ecr_pkg::NUM_EVO-1:0] event_pin_output
);
  import ecr_pkg::*;

  logic [7:0] ch_sel_r [NUM_CH];
  logic [7:0] ch_sel_nxt [NUM_CH];
  logic [7:0] evo_sel_r [NUM_EVO];
  logic [7:0] evo_sel_nxt [NUM_EVO];
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [PIT_CNT_W-1:0] pit_cnt_r;
  logic [PIT_CNT_W-1:0] pit_cnt_nxt;
  logic pit_clk_s;
  logic pit_clk_d_r;
  logic [NUM_CH-1:0] chan_retimed;
  logic high_byte_underflow_gated;

  // true when the selected generator is not clocked by clk_sys
  function automatic logic gen_is_async(input logic [7:0] sel);
    logic r;
    r = 1'b0;
    if (sel == GEN_RTC_OVF || sel == GEN_RTC_CMP || sel == GEN_AC) begin
      r = 1'b1;
    end
    if ((sel & MASK_GRP4) == GEN_LUT_BASE) begin
      r = 1'b1;
    end
    if ((sel & MASK_GRP8) == GEN_PIN_BASE) begin
      r = 1'b1;
    end
    return r;
  endfunction

  // generator multiplexer; unknown codes and zero give a quiet channel
  function automatic logic gen_pick(
    input logic [7:0] sel,
    input logic odd,
    input logic [PIT_CNT_W-1:0] pit,
    input logic [15:0] misc,
    input logic [NUM_LUT-1:0] lut,
    input logic [NUM_PIN-1:0] pin,
    input logic [NUM_TCMP-1:0] tcmp
  );
    logic r;
    r = 1'b0;
    case (sel)
      GEN_RTC_OVF: r = misc[0];
      GEN_RTC_CMP: r = misc[1];
      GEN_AC: r = misc[2];
      GEN_CONV_RES: r = misc[3];
      GEN_CONV_SAMPLE_READY: r = misc[4];
      GEN_CONV_WINDOW_COMPARE_MATCH: r = misc[5];
      GEN_USART: r = misc[6];
      GEN_SPI: r = misc[7];
      GEN_TMR_OVF: r = misc[8];
      GEN_TMR_HIGH_BYTE_UNDERFLOW: r = misc[9];
      GEN_CAP_CAPTURE_EVENT_INPUT: r = misc[10];
      GEN_CAP_OVF: r = misc[11];
      default: r = 1'b0;
    endcase
    // even channels carry the slow taps, odd ones the fast taps
    if ((sel & MASK_GRP4) == GEN_PIT_BASE) begin
      r = odd ? pit[PIT_TOP_ODD - int'(sel[1:0])]
              : pit[PIT_TOP_EVEN - int'(sel[1:0])];
    end
    if ((sel & MASK_GRP4) == GEN_LUT_BASE) begin
      r = lut[sel[1:0]];
    end
    if ((sel & MASK_GRP8) == GEN_PIN_BASE) begin
      r = pin[sel[2:0]];
    end
    if (sel >= GEN_TMR_CMP_BASE && sel < GEN_TMR_CMP_BASE + 8'h03) begin
      r = tcmp[sel[1:0]];
    end
    return r;
  endfunction

  // prescaled interval clock is foreign: two flops before use
  ecr_sync u_pit_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d(rtc_prescaled_clk),
    .q(pit_clk_s)
  );

  // interval counter steps on each rising prescaled edge
  always_comb begin
    pit_cnt_nxt = pit_cnt_r;
    if (pit_clk_s && !pit_clk_d_r) begin
      pit_cnt_nxt = pit_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pit_cnt_r <= '0;
      pit_clk_d_r <= 1'b0;
    end else begin
      pit_cnt_r <= pit_cnt_nxt;
      pit_clk_d_r <= pit_clk_s;
    end
  end

  // underflow of the high byte exists only while split
  assign high_byte_underflow_gated = wide_timer_split & wide_timer_high_byte_underflow;

  // per channel: async path straight, sync path via chain or bypass
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign chan_async[i] = gen_pick(ch_sel_r[i], (i % 2) == 1, pit_cnt_r,
      {4'h0, capture_timer_ovf, capture_timer_capture_event_input, high_byte_underflow_gated,
       wide_timer_overflow_or_low_underflow, spi_host_clock,
       serial_baud_clock, converter_window_compare_match,
       converter_sample_ready, converter_result_ready,
       analog_comparator, rtc_compare, rtc_overflow},
      lookup_output, port_pin, wide_timer_compare_match);

    // chain always runs, so a selector change costs no extra glitch
    ecr_sync u_retime (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .d(chan_async[i]),
      .q(chan_retimed[i])
    );

    assign chan_sync[i] = gen_is_async(ch_sel_r[i]) ? chan_retimed[i]
                                                    : chan_async[i];
  end

  // pin outputs: no detection, purely combinational path
  for (genvar j = 0; j < NUM_EVO; j++) begin : g_evo
    assign event_pin_output[j] =
      (evo_sel_r[j] != 8'h00 && evo_sel_r[j] <= 8'(NUM_CH))
        ? chan_async[3'(evo_sel_r[j] - 8'h01)] : 1'b0;
  end

  // register writes and one-cycle-late reads
  always_comb begin
    ch_sel_nxt = ch_sel_r;
    evo_sel_nxt = evo_sel_r;
    rdata_nxt = 8'h00;
    for (int k = 0; k < NUM_CH; k++) begin
      if (reg_wr && reg_addr == OFS_CH0 + 8'(k)) begin
        ch_sel_nxt[k] = reg_wdata;
      end
      if (reg_rd && reg_addr == OFS_CH0 + 8'(k)) begin
        rdata_nxt = ch_sel_r[k];
      end
    end
    for (int k = 0; k < NUM_EVO; k++) begin
      if (reg_wr && reg_addr == OFS_EVO0 + 8'(k)) begin
        evo_sel_nxt[k] = reg_wdata;
      end
      if (reg_rd && reg_addr == OFS_EVO0 + 8'(k)) begin
        rdata_nxt = evo_sel_r[k];
      end
    end
    if (reg_rd && reg_addr == OFS_STAT) begin
      rdata_nxt = {2'h0, chan_sync};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int k = 0; k < NUM_CH; k++) begin
        ch_sel_r[k] <= RST_SEL;
      end
      for (int k = 0; k < NUM_EVO; k++) begin
        evo_sel_r[k] <= RST_SEL;
      end
      rdata_r <= 8'h00;
    end else begin
      ch_sel_r <= ch_sel_nxt;
      evo_sel_r <= evo_sel_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // checks on channel 0 and pin output 0
  off_quiet_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ch_sel_r[0] == GEN_OFF |-> !chan_async[0] && !chan_sync[0])
    else $error("channel off but active");

  reset_off_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    $past(sys_rst) |-> ch_sel_r[0] == GEN_OFF)
    else $error("selector not cleared by reset");

  high_byte_underflow_gate_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ch_sel_r[0] == GEN_TMR_HIGH_BYTE_UNDERFLOW && !wide_timer_split |-> !chan_sync[0])
    else $error("high underflow outside split mode");

  sync_bypass_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ch_sel_r[0] == GEN_TMR_OVF
      |-> chan_sync[0] == wide_timer_overflow_or_low_underflow)
    else $error("sync generator not bypassed");

  async_pass_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ch_sel_r[0] == GEN_AC |-> chan_async[0] == analog_comparator)
    else $error("async subchannel differs from source");

  retime_delay_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (ch_sel_r[0] == GEN_AC)[*3] |-> chan_sync[0] == $past(chan_async[0], 2))
    else $error("retimed copy not two cycles late");

  pin_fwd_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    evo_sel_r[0] == 8'h01 |-> event_pin_output[0] == chan_async[0])
    else $error("pin output not following channel");

  pit_tap_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ch_sel_r[0] == GEN_PIT_BASE |-> chan_async[0] == pit_cnt_r[PIT_TOP_EVEN])
    else $error("slowest tap wrong on even channel");

  read_back_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    reg_rd && reg_addr == OFS_CH0 |=> reg_rdata == $past(ch_sel_r[0]))
    else $error("selector read back wrong");
endmodule

/* ecr_sync.sv */
`timescale 1ns/1ps
// plain flip-flop chain onto clk_sys
module ecr_sync
  import ecr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic d,
  output logic q
);
  logic [SYNC_STAGES-1:0] stg_r;
  logic [SYNC_STAGES-1:0] stg_nxt;

  // shift; only the next stage reads the first one
  always_comb begin
    stg_nxt = {stg_r[SYNC_STAGES-2:0], d};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stg_r <= '0;
    end else begin
      stg_r <= stg_nxt;
    end
  end

  assign q = stg_r[SYNC_STAGES-1];
endmodule

/* testbench.sv */
`timescale 1ns/1ps
// random traffic through the router, checked each cycle against a model
module testbench;
  import ecr_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
  logic reg_wr = 1'b0, reg_rd = 1'b0, split = 1'b0, rogue = 1'b0;
  logic rtc_overflow = 1'b0, rtc_compare = 1'b0, analog_comparator = 1'b0;
  logic [NUM_LUT-1:0] lookup_output = '0;
  logic [NUM_PIN-1:0] port_pin = '0;
  logic [2:0] conv, tmr_cmp;
  logic [1:0] cap;
  logic tmr_ovf, tmr_high_byte_underflow, baud, sck, chk_on = 1'b0, ea;
  logic [NUM_CH-1:0] chan_async, chan_sync, h1 = '0, h2 = '0;
  logic [NUM_EVO-1:0] evo;
  logic [7:0] sel_sh [NUM_CH];
  logic [7:0] evo_sh [NUM_EVO] = '{8'h00, 8'h00};
  int n_mismatch = 0, compares = 0, k, ev_ch;
  logic pre_clk = 1'b0, ue_d = 1'b0, u_ok = 1'b0;
  logic [2:0] pre_d = 3'h0;
  logic [PIT_CNT_W-1:0] pit_m = '0;
  logic [7:0] user_cnt, ucnt = 8'h00;
  logic [NUM_CH-1:0] sync_exp = '0, sync_prev = '0;
  // channel 0 corner codes for the late passes: tap, timer, comparator,
  // high underflow
  int dk [4] = '{28, 21, 7, 22};
  logic [7:0] codes [34] = '{8'h00, 8'h06, 8'h07, 8'h10, 8'h11, 8'h12,
    8'h13, 8'h20, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47,
    8'h24, 8'h25, 8'h26, 8'h60, 8'h61, 8'h80, 8'h81, 8'h84, 8'h85, 8'h86,
    8'ha0, 8'ha1, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h87, 8'hff};

  ecr_router u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rtc_overflow(rtc_overflow),
    .rtc_compare(rtc_compare), .rtc_prescaled_clk(pre_clk),
    .lookup_output(lookup_output), .analog_comparator(analog_comparator),
    .port_pin(port_pin), .converter_result_ready(conv[0]),
    .converter_sample_ready(conv[1]),
    .converter_window_compare_match(conv[2]), .serial_baud_clock(baud),
    .spi_host_clock(sck), .wide_timer_split(split),
    .wide_timer_overflow_or_low_underflow(tmr_ovf),
    .wide_timer_high_byte_underflow(tmr_high_byte_underflow),
    .wide_timer_compare_match(tmr_cmp), .capture_timer_capture_event_input(cap[0]),
    .capture_timer_ovf(cap[1]), .chan_async(chan_async),
    .chan_sync(chan_sync), .event_pin_output(evo));
  ecr_gen_model u_gen (.clk_sys(clk_sys), .sys_rst(sys_rst), .split(split),
    .rogue(rogue), .conv(conv), .tmr_ovf(tmr_ovf), .tmr_high_byte_underflow(tmr_high_byte_underflow),
    .tmr_cmp(tmr_cmp), .cap(cap), .baud(baud), .sck(sck),
    .user_ev(chan_sync[0]), .user_cnt(user_cnt));

  always #12.5 clk_sys = ~clk_sys;

  // expected generator level for a selector code on channel ch
  function automatic logic exp_gen(input logic [7:0] c, input int ch);
    if (c[7:2] == 6'h02) begin
      return pit_m[((ch % 2 == 1) ? 8 : 12) - int'(c[1:0])];
    end
    if (c[7:3] == 5'h08) return port_pin[c[2:0]];
    if (c[7:2] == 6'h04) return lookup_output[c[1:0]];
    if (c[7:2] == 6'h21 && c[1:0] != 2'h3) return tmr_cmp[c[1:0]];
    if (c[7:2] == 6'h09 && c[1:0] != 2'h3) return conv[c[1:0]];
    case (c)
      8'h06: return rtc_overflow;
      8'h07: return rtc_compare;
      8'h20: return analog_comparator;
      8'h60: return baud;
      8'h61: return sck;
      8'h80: return tmr_ovf;
      8'h81: return tmr_high_byte_underflow & split;
      8'ha0: return cap[0];
      8'ha1: return cap[1];
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic is_async(input logic [7:0] c);
    return c == 8'h06 || c == 8'h07 || c == 8'h20 || c[7:2] == 6'h04 ||
      c[7:3] == 5'h08;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // an idle edge, so a following write never reassigns the strobe
    @(posedge clk_sys);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask

  task automatic print_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // async sources change every cycle, so each level lasts a full cycle
  always @(posedge clk_sys) begin
    {rtc_overflow, rtc_compare, analog_comparator} <= 3'($urandom);
    lookup_output <= 4'($urandom);
    port_pin <= 8'($urandom);
    // prescaled clock toggles each cycle; the model counts its rising
    // edges three edges late, as two sync flops and an edge flop do
    pre_clk <= ~pre_clk;
    if (sys_rst) begin
      pre_d <= 3'h0;
      pit_m <= '0;
    end else begin
      pre_d <= {pre_d[1:0], pre_clk};
      if (pre_d[1] && !pre_d[2]) pit_m <= pit_m + 1'b1;
    end
  end

  // sampled mid-cycle, where all combinational paths have settled
  always @(negedge clk_sys) begin
    for (int c = 0; c < NUM_CH; c++) begin
      ea = exp_gen(sel_sh[c], c);
      if (chk_on) begin
        chk({7'h0, chan_async[c]}, {7'h0, ea});
        if (is_async(sel_sh[c])) begin
          chk({7'h0, chan_sync[c]}, {7'h0, h2[c]});
        end else begin
          chk({7'h0, chan_sync[c]}, {7'h0, ea});
        end
      end
      sync_prev[c] = sync_exp[c];
      sync_exp[c] = is_async(sel_sh[c]) ? h2[c] : ea;
      h2[c] = h1[c];
      h1[c] = ea;
    end
    for (int j = 0; j < NUM_EVO; j++) begin
      ev_ch = int'(evo_sh[j]) - 1;
      if (chk_on && ev_ch >= 0 && ev_ch < NUM_CH) begin
        chk({7'h0, evo[j]}, {7'h0, exp_gen(sel_sh[ev_ch], ev_ch)});
      end else if (chk_on) begin
        chk({7'h0, evo[j]}, 8'h00);
      end
    end
    // user on channel 0; only trusted after a rising edge seen while
    // the selectors are settled, since a restart clears all history
    if (chk_on && u_ok) chk(user_cnt, ucnt);
    if (sync_exp[0] && !ue_d) begin
      ucnt = 8'h00;
      u_ok = chk_on;
    end else begin
      ucnt = sync_exp[0] ? ucnt - 8'h01 : ucnt + 8'h01;
    end
    ue_d = sync_exp[0];
    if (!chk_on) u_ok = 1'b0;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    print_verdict;
  end

  initial begin
    void'($urandom(32'h7a4e84cc));
    for (int c = 0; c < NUM_CH; c++) sel_sh[c] = GEN_OFF;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk_on = 1'b1;
    for (int c = 0; c < NUM_CH; c++) begin
      reg_read(OFS_CH0 + 8'(c), rd_val);
      chk(rd_val, RST_SEL);
    end
    reg_write(8'h05, 8'h5a);
    reg_read(8'h05, rd_val);
    chk(rd_val, 8'h00);
    // first six passes walk every code, later ones pick at random except channel 0 corner codes and a last pass all off
    for (int i = 0; i < 17; i++) begin
      chk_on = 1'b0;
      split <= (i >= 15) ? 1'b0 : 1'($urandom);
      rogue <= i[1];
      for (int c = 0; c < NUM_CH; c++) begin
        k = (i < 6) ? (i * NUM_CH + c) % 34 : $urandom_range(33);
        if (c == 0 && i >= 12 && i < 16) k = dk[i - 12];
        if (i == 16) k = 0;
        sel_sh[c] = codes[k];
        reg_write(OFS_CH0 + 8'(c), codes[k]);
      end
      for (int j = 0; j < NUM_EVO; j++) begin
        evo_sh[j] = 8'($urandom_range(7));
        reg_write(OFS_EVO0 + 8'(j), evo_sh[j]);
      end
      for (int c = 0; c < NUM_CH; c++) begin
        reg_read(OFS_CH0 + 8'(c), rd_val);
        chk(rd_val, sel_sh[c]);
      end
      chk_on = 1'b1;
      repeat (40) @(posedge clk_sys);
      // status holds the sync subchannels as they stood at the strobe
      reg_read(OFS_STAT, rd_val);
      chk(rd_val, {2'h0, sync_prev});
    end
    print_verdict;
  end
endmodule
